// *** hdl/nmp_ctrl.sv ***
// Function
// - pin-only completion: last page uses 10h
// - cache confirm on last page: poll bit 5
// - no cache program on boot blocks 0-3
// - final plane confirm programs all queued planes
// - setup, five address cycles, data, 85h anytime
// - page program ends pair: check bit 0
// - cache program ends pair: check bit 1
// - 70h combined result, 78h finds plane
// - plane bit low first, high second
// - both planes same operation type
// - after 11h only 70h, 78h, FFh, 81h, 85h
// - copy back 00h-35h, same plane only
// - copy back program 85h-addr-10h
// - column changes modify cache before confirm
//
// Chosen here: the register offsets and register access over APB.
module nmp_ctrl import nmp_pkg::*; (
	input wire logic clk_sys, // 40 MHz system clock
	input wire logic sys_rst, // sync reset, active high
	input wire logic clk_en, // freezes all state when low
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb direction
	input wire logic [7:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error
	output logic nand_ce_n, // chip enable, active low
	output logic nand_cle, // command latch enable
	output logic nand_ale, // address latch enable
	output logic nand_we_n, // write strobe, active low
	output logic read_strobe_n, // read strobe, active low
	output logic [7:0] nand_io_out, // data pins out
	output logic nand_io_oe_n, // low while driving data pins
	input wire logic [7:0] nand_io_in, // data pins in
	input wire logic ready_busy_n_pin // high when cache ready
);
	typedef enum logic [3:0] {
		E_IDLE = 4'b0000,
		E_CMD = 4'b0001,
		E_ADDR = 4'b0010,
		E_LAG = 4'b0011,
		E_WAIT = 4'b0100,
		E_PCMD = 4'b0101,
		E_PRD = 4'b0110,
		E_DWR = 4'b0111,
		E_DRD = 4'b1000
	} nmp_eng_t;

	function automatic logic [7:0] addr_byte(input logic [2:0] idx, input logic [2:0] acnt,
			input logic [15:0] col, input logic [16:0] row);
		logic [2:0] k;
		// row-only sequences skip the two column bytes
		k = (acnt == 3'd3) ? idx + 3'd2 : idx;
		case (k)
			3'd0: return col[7:0];
			3'd1: return col[15:8];
			3'd2: return row[7:0];
			3'd3: return row[15:8];
			default: return {7'h00, row[16]};
		endcase
	endfunction

	function automatic logic is_stat_cmd(input logic [7:0] c);
		return (c == CMD_STATUS) || (c == CMD_STATUS_ENH) || (c == CMD_RESET);
	endfunction

	nmp_eng_t eng_q;
	nmp_seq_t seq_q;
	logic [15:0] col_q;
	logic [16:0] row_q, su_row_q;
	logic [2:0] aidx_q;
	logic [7:0] lag_q, stat_q, dbyte_q;
	logic [1:0] cfg_q;
	logic pend_q, start_q, polling_q, rd_ok_q;
	logic q_await_q, tp_q, cb_valid_q, cb_plane_q;
	logic fail_cur_q, fail_prev_q, enh_hint_q, refused_q;
	nmp_kind_t kind_q;
	nmp_strobe_t strb;
	logic [7:0] rbyte;
	logic cyc_done;

	nmp_cycle u_cycle (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.start(start_q),
		.kind(kind_q),
		.wbyte(dbyte_q),
		.io_in(nand_io_in),
		.strb(strb),
		.io_out(nand_io_out),
		.io_oe_n(nand_io_oe_n),
		.rbyte(rbyte),
		.done(cyc_done)
	);
	assign nand_cle = strb.cle;
	assign nand_ale = strb.ale;
	assign nand_we_n = strb.we_n;
	assign read_strobe_n = strb.re_n;

	////////////////////////////////////////////////////////////////////////////
	// bus decode and order checks

	nmp_seq_t req;
	logic acc, fire, hit_seq, hit_data, mapped, refuse, busy_pin, poll_mode;
	logic new_plane, su_plane;
	logic [9:0] su_block;
	assign req = nmp_seq_t'(pwdata[13:0]);
	assign acc = psel && penable && !pready;
	assign fire = psel && penable && pready;
	assign hit_seq = (paddr == OFS_SEQ);
	assign hit_data = (paddr == OFS_DATA);
	assign mapped = hit_seq || hit_data || (paddr == OFS_COL) || (paddr == OFS_ROW)
		|| (paddr == OFS_STAT) || (paddr == OFS_CFG);
	assign busy_pin = !ready_busy_n_pin;
	assign poll_mode = cfg_q[0];
	assign new_plane = row_q[PLANE_BIT];
	assign su_plane = su_row_q[PLANE_BIT];
	assign su_block = su_row_q[16:BLOCK_LSB];

	always_comb begin
		refuse = 1'b0;
		if (pwrite && hit_seq) begin
			if (busy_pin && !is_stat_cmd(req.cmd))
				refuse = 1'b1;
			if (q_await_q && !is_stat_cmd(req.cmd) && req.cmd != CMD_PLANE_SETUP
					&& req.cmd != CMD_COL_CHANGE)
				refuse = 1'b1;
			if (tp_q && (req.cmd == CMD_ERASE || req.cmd == CMD_ERASE_Q))
				refuse = 1'b1;
			if (req.cmd == CMD_QUEUE && !tp_q && su_plane)
				refuse = 1'b1;
			if ((req.cmd == CMD_PROG || req.cmd == CMD_CACHE) && tp_q && !su_plane)
				refuse = 1'b1;
			if (req.cmd == CMD_CACHE && cfg_q[1] && su_block < BOOT_BLOCKS)
				refuse = 1'b1;
			if (req.cmd == CMD_CACHE && req.fin && !poll_mode)
				refuse = 1'b1;
			if (req.cmd == CMD_COL_CHANGE && req.acnt == 3'd5 && cb_valid_q
					&& new_plane != cb_plane_q)
				refuse = 1'b1;
		end
	end

	// writes and reads to the engine wait for it to go idle; a data read
	// answers only once its strobe cycle has sampled the pins
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else if (clk_en) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			if (acc) begin
				if (!mapped) begin
					pready <= 1'b1;
					pslverr <= 1'b1;
					prdata <= 32'h0000_0000;
				end else if (hit_data && !pwrite) begin
					if (rd_ok_q) begin
						pready <= 1'b1;
						prdata <= {24'h000000, rbyte};
					end
				end else if ((hit_seq || hit_data) && eng_q != E_IDLE) begin
					pready <= 1'b0;
				end else begin
					pready <= 1'b1;
					pslverr <= refuse;
					if (paddr == OFS_COL)
						prdata <= {16'h0000, col_q};
					else if (paddr == OFS_ROW)
						prdata <= {15'h0000, row_q};
					else if (paddr == OFS_STAT)
						prdata <= {17'h00000, tp_q, refused_q, enh_hint_q, fail_prev_q,
							fail_cur_q, ready_busy_n_pin, eng_q != E_IDLE, stat_q};
					else if (paddr == OFS_CFG)
						prdata <= {30'h00000000, cfg_q};
					else
						prdata <= 32'h0000_0000;
				end
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			col_q <= 16'h0000;
			row_q <= 17'h00000;
			cfg_q <= CFG_RST;
		end else if (clk_en && fire && pwrite) begin
			if (paddr == OFS_COL)
				col_q <= pwdata[15:0];
			else if (paddr == OFS_ROW)
				row_q <= pwdata[16:0];
			else if (paddr == OFS_CFG)
				cfg_q <= pwdata[1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// sequence tracking across commands

	logic launch;
	assign launch = fire && pwrite && hit_seq && !pslverr;

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			su_row_q <= 17'h00000;
			q_await_q <= 1'b0;
			tp_q <= 1'b0;
			cb_valid_q <= 1'b0;
			cb_plane_q <= 1'b0;
		end else if (clk_en && launch) begin
			if (req.acnt == 3'd5)
				su_row_q <= row_q;
			case (req.cmd)
				CMD_QUEUE: begin
					q_await_q <= 1'b1;
					tp_q <= 1'b1;
				end
				CMD_PLANE_SETUP, CMD_COL_CHANGE: q_await_q <= 1'b0;
				CMD_PROG, CMD_CACHE: begin
					tp_q <= 1'b0;
					cb_valid_q <= 1'b0;
				end
				CMD_CB_READ: begin
					cb_valid_q <= 1'b1;
					cb_plane_q <= su_plane;
				end
				CMD_RESET: begin
					q_await_q <= 1'b0;
					tp_q <= 1'b0;
					cb_valid_q <= 1'b0;
				end
				default: q_await_q <= q_await_q;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// pin sequencer

	logic ready_bit;
	assign ready_bit = seq_q.fin ? rbyte[SR_ARRAY] : rbyte[SR_CACHE];

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			eng_q <= E_IDLE;
			seq_q <= '0;
			aidx_q <= 3'd0;
			lag_q <= 8'h00;
			pend_q <= 1'b0;
			start_q <= 1'b0;
			kind_q <= CK_CMD;
			dbyte_q <= 8'h00;
			polling_q <= 1'b0;
			rd_ok_q <= 1'b0;
			nand_ce_n <= 1'b1;
		end else if (clk_en) begin
			start_q <= 1'b0;
			rd_ok_q <= 1'b0;
			nand_ce_n <= 1'b0;
			case (eng_q)
				E_IDLE: begin
					pend_q <= 1'b0;
					polling_q <= 1'b0;
					if (launch) begin
						seq_q <= req;
						eng_q <= E_CMD;
					end else if (fire && pwrite && hit_data) begin
						dbyte_q <= pwdata[7:0];
						eng_q <= E_DWR;
					end else if (acc && !pwrite && hit_data && !rd_ok_q) begin
						eng_q <= E_DRD;
					end
				end
				E_LAG: begin
					// the busy pin lags the confirm edge
					if (lag_q != 8'h00)
						lag_q <= lag_q - 8'h01;
					else if (poll_mode)
						eng_q <= E_PCMD;
					else
						eng_q <= E_WAIT;
				end
				E_WAIT: begin
					if (ready_busy_n_pin)
						eng_q <= seq_q.stat ? E_PCMD : E_IDLE;
				end
				default: begin
					if (!pend_q) begin
						start_q <= 1'b1;
						pend_q <= 1'b1;
						case (eng_q)
							E_CMD: begin
								kind_q <= CK_CMD;
								dbyte_q <= seq_q.cmd;
							end
							E_ADDR: begin
								kind_q <= CK_ADDR;
								dbyte_q <= addr_byte(aidx_q, seq_q.acnt, col_q, row_q);
							end
							E_PCMD: begin
								kind_q <= CK_CMD;
								dbyte_q <= CMD_STATUS;
							end
							E_DWR: kind_q <= CK_WR;
							default: kind_q <= CK_RD;
						endcase
					end else if (cyc_done) begin
						pend_q <= 1'b0;
						case (eng_q)
							E_CMD: begin
								aidx_q <= 3'd0;
								if (seq_q.acnt != 3'd0)
									eng_q <= E_ADDR;
								else if (seq_q.wait_rdy || seq_q.cmd == CMD_QUEUE) begin
									lag_q <= 8'(BUSY_LAG_CYC - 1);
									polling_q <= 1'b1;
									eng_q <= E_LAG;
								end else
									eng_q <= seq_q.stat ? E_PCMD : E_IDLE;
							end
							E_ADDR: begin
								aidx_q <= aidx_q + 3'd1;
								if (aidx_q == seq_q.acnt - 3'd1) begin
									if (seq_q.wait_rdy) begin
										lag_q <= 8'(BUSY_LAG_CYC - 1);
										polling_q <= 1'b1;
										eng_q <= E_LAG;
									end else
										eng_q <= E_IDLE;
								end
							end
							E_PCMD: eng_q <= E_PRD;
							E_PRD: begin
								// keep polling until the chosen ready bit rises
								if (polling_q && poll_mode && !ready_bit)
									eng_q <= E_PRD;
								else
									eng_q <= E_IDLE;
							end
							E_DRD: begin
								rd_ok_q <= 1'b1;
								eng_q <= E_IDLE;
							end
							default: eng_q <= E_IDLE;
						endcase
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// result flags; a new failure wins over a clear in the same cycle

	logic stat_done, clr_wr;
	assign stat_done = (eng_q == E_PRD) && cyc_done && pend_q
		&& !(polling_q && poll_mode && !ready_bit);
	assign clr_wr = fire && pwrite && (paddr == OFS_STAT);

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			stat_q <= 8'h00;
			fail_cur_q <= 1'b0;
			fail_prev_q <= 1'b0;
			enh_hint_q <= 1'b0;
			refused_q <= 1'b0;
		end else if (clk_en) begin
			if (clr_wr) begin
				fail_cur_q <= fail_cur_q & ~pwdata[10];
				fail_prev_q <= fail_prev_q & ~pwdata[11];
				enh_hint_q <= enh_hint_q & ~pwdata[12];
				refused_q <= refused_q & ~pwdata[13];
			end
			if (fire && pslverr && hit_seq)
				refused_q <= 1'b1;
			if (stat_done) begin
				stat_q <= rbyte;
				if (rbyte[SR_ARRAY] && rbyte[SR_PASS])
					fail_cur_q <= 1'b1;
				if (rbyte[SR_CACHE] && rbyte[SR_PREV])
					fail_prev_q <= 1'b1;
				if (rbyte[SR_PASS] || rbyte[SR_PREV])
					enh_hint_q <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb_clk @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	busy_refuse_a: assert property (acc && pwrite && hit_seq && busy_pin && mapped
		&& !is_stat_cmd(req.cmd) && eng_q == E_IDLE && clk_en |=> pslverr)
		else $error("command accepted while device busy");
	boot_guard_a: assert property (acc && pwrite && hit_seq && req.cmd == CMD_CACHE && cfg_q[1]
		&& su_block < BOOT_BLOCKS && eng_q == E_IDLE && clk_en |=> pslverr && pready)
		else $error("cache program allowed on boot block");
	pin_last_a: assert property (acc && pwrite && hit_seq && req.cmd == CMD_CACHE && req.fin
		&& !poll_mode && eng_q == E_IDLE && clk_en |=> pslverr)
		else $error("final cache confirm allowed in pin mode");
	queue_only_a: assert property (launch && clk_en |-> !q_await_q || is_stat_cmd(req.cmd)
		|| req.cmd == CMD_PLANE_SETUP || req.cmd == CMD_COL_CHANGE)
		else $error("illegal command after plane queue");
	plane_order_a: assert property (launch && clk_en && tp_q
		&& (req.cmd == CMD_PROG || req.cmd == CMD_CACHE) |-> su_plane)
		else $error("final plane address has plane bit low");
	dummy_busy_a: assert property (eng_q == E_CMD && seq_q.cmd == CMD_QUEUE && pend_q && cyc_done
		&& seq_q.acnt == 3'd0 && clk_en |=> eng_q == E_LAG ##1 eng_q == E_LAG || !clk_en
		|| BUSY_LAG_CYC == 1)
		else $error("queue confirm did not wait for dummy busy");
	cur_fail_a: assert property (stat_done && rbyte[SR_ARRAY] && rbyte[SR_PASS] && clk_en
		|=> fail_cur_q && stat_q == $past(rbyte))
		else $error("current fail not recorded");
	prev_fail_a: assert property (stat_done && rbyte[SR_CACHE] && rbyte[SR_PREV] && clk_en
		|=> fail_prev_q)
		else $error("previous page fail not recorded");
	cb_plane_a: assert property (launch && clk_en && req.cmd == CMD_COL_CHANGE
		&& req.acnt == 3'd5 && cb_valid_q |-> new_plane == cb_plane_q)
		else $error("copy back across planes");
	wait_pin_a: assert property (eng_q == E_WAIT && busy_pin |=> eng_q == E_WAIT)
		else $error("left wait while busy pin low");

	cache_poll_c: cover property (launch && req.cmd == CMD_CACHE && req.fin);
	plane_queue_c: cover property (launch && req.cmd == CMD_QUEUE);
	copy_back_c: cover property (launch && req.cmd == CMD_COL_CHANGE && cb_valid_q);
	fail_seen_c: cover property (stat_done && rbyte[SR_PASS]);
endmodule // nmp_ctrl

// *** hdl/nmp_pkg.sv ***
package nmp_pkg;
	localparam int CLK_MHZ = 40;
	localparam int STROBE_LOW_NS = 25;
	localparam int STROBE_HIGH_NS = 25;
	localparam int BUSY_LAG_NS = 100;

	function automatic int ns_to_cyc(input int ns);
		int c;
		c = (ns * CLK_MHZ + 999) / 1000;
		return (c < 1) ? 1 : c;
	endfunction

	localparam int STROBE_LOW_CYC = ns_to_cyc(STROBE_LOW_NS);
	localparam int STROBE_HIGH_CYC = ns_to_cyc(STROBE_HIGH_NS);
	localparam int BUSY_LAG_CYC = ns_to_cyc(BUSY_LAG_NS);

	localparam logic [7:0] OFS_SEQ = 8'h00;
	localparam logic [7:0] OFS_COL = 8'h04;
	localparam logic [7:0] OFS_ROW = 8'h08;
	localparam logic [7:0] OFS_DATA = 8'h0c;
	localparam logic [7:0] OFS_STAT = 8'h10;
	localparam logic [7:0] OFS_CFG = 8'h14;

	localparam logic [7:0] CMD_READ = 8'h00;
	localparam logic [7:0] CMD_CB_READ = 8'h35;
	localparam logic [7:0] CMD_PROG_SETUP = 8'h80;
	localparam logic [7:0] CMD_PLANE_SETUP = 8'h81;
	localparam logic [7:0] CMD_COL_CHANGE = 8'h85;
	localparam logic [7:0] CMD_PROG = 8'h10;
	localparam logic [7:0] CMD_CACHE = 8'h15;
	localparam logic [7:0] CMD_QUEUE = 8'h11;
	localparam logic [7:0] CMD_STATUS = 8'h70;
	localparam logic [7:0] CMD_STATUS_ENH = 8'h78;
	localparam logic [7:0] CMD_RESET = 8'hff;
	localparam logic [7:0] CMD_ERASE = 8'hd0;
	localparam logic [7:0] CMD_ERASE_Q = 8'hd1;

	localparam int SR_PASS = 0;
	localparam int SR_PREV = 1;
	localparam int SR_ARRAY = 5;
	localparam int SR_CACHE = 6;
	localparam int PLANE_BIT = 6;
	localparam int BLOCK_LSB = 7;
	localparam logic [9:0] BOOT_BLOCKS = 10'h004;
	localparam logic [1:0] CFG_RST = 2'h2;

	typedef struct packed {
		logic fin;
		logic stat;
		logic wait_rdy;
		logic [2:0] acnt;
		logic [7:0] cmd;
	} nmp_seq_t;

	typedef enum logic [1:0] {
		CK_CMD = 2'b00,
		CK_ADDR = 2'b01,
		CK_WR = 2'b10,
		CK_RD = 2'b11
	} nmp_kind_t;

	typedef struct packed {
		logic cle;
		logic ale;
		logic we_n;
		logic re_n;
	} nmp_strobe_t;
endpackage

////////////////////////////////////////////////////////////////////////////////

module nmp_cycle import nmp_pkg::*; (
	input wire logic clk_sys, // system clock
	input wire logic sys_rst, // sync reset
	input wire logic clk_en, // freezes state when low
	input wire logic start, // begin one bus cycle
	input wire nmp_kind_t kind, // cycle type
	input wire logic [7:0] wbyte, // byte to drive
	input wire logic [7:0] io_in, // data pins in
	output nmp_strobe_t strb, // latch enables and strobes
	output logic [7:0] io_out, // data pins out
	output logic io_oe_n, // low while driving pins
	output logic [7:0] rbyte, // byte sampled on read
	output logic done // cycle finished pulse
);
	typedef enum logic [1:0] {
		CY_IDLE = 2'b00,
		CY_SETUP = 2'b01,
		CY_LOW = 2'b10,
		CY_HIGH = 2'b11
	} nmp_cy_t;

	nmp_cy_t st_q;
	nmp_kind_t kind_q;
	logic [7:0] cnt_q;

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			st_q <= CY_IDLE;
			kind_q <= CK_CMD;
			cnt_q <= 8'h00;
			strb <= '{cle: 1'b0, ale: 1'b0, we_n: 1'b1, re_n: 1'b1};
			io_out <= 8'h00;
			io_oe_n <= 1'b1;
			rbyte <= 8'h00;
			done <= 1'b0;
		end else if (clk_en) begin
			done <= 1'b0;
			case (st_q)
				CY_IDLE: begin
					if (start) begin
						kind_q <= kind;
						strb.cle <= (kind == CK_CMD);
						strb.ale <= (kind == CK_ADDR);
						io_out <= wbyte;
						io_oe_n <= (kind == CK_RD);
						st_q <= CY_SETUP;
					end
				end
				CY_SETUP: begin
					if (kind_q == CK_RD) begin
						strb.re_n <= 1'b0;
					end else begin
						strb.we_n <= 1'b0;
					end
					cnt_q <= 8'(STROBE_LOW_CYC - 1);
					st_q <= CY_LOW;
				end
				CY_LOW: begin
					if (cnt_q != 8'h00) begin
						cnt_q <= cnt_q - 8'h01;
					end else begin
						// sample before the rising read strobe releases the pins
						if (kind_q == CK_RD) begin
							rbyte <= io_in;
						end
						strb.we_n <= 1'b1;
						strb.re_n <= 1'b1;
						cnt_q <= 8'(STROBE_HIGH_CYC - 1);
						st_q <= CY_HIGH;
					end
				end
				CY_HIGH: begin
					if (cnt_q != 8'h00) begin
						cnt_q <= cnt_q - 8'h01;
					end else begin
						strb.cle <= 1'b0;
						strb.ale <= 1'b0;
						io_oe_n <= 1'b1;
						done <= 1'b1;
						st_q <= CY_IDLE;
					end
				end
				default: st_q <= CY_IDLE;
			endcase
		end
	end
endmodule // nmp_cycle

// *** test/nmp_flash_model.sv ***
module nmp_flash_model (
	input wire logic clk_sys, // bench clock, samples the strobes and times busy
	input wire logic ce_n, // chip enable
	input wire logic cle, // command latch enable
	input wire logic ale, // address latch enable
	input wire logic we_n, // write strobe
	input wire logic re_n, // read strobe
	input wire logic [7:0] din, // resolved data pins
	input wire logic fail_inj, // next program reports a failure
	output logic [7:0] dout, // device drive toward the pins
	output logic rb // ready_busy_n_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] cache [0:15];
	logic [7:0] prog [0:15];
	logic [7:0] last = 8'h00;
	logic [7:0] sr;
	logic [2:0] ac = 3'h0;
	logic [15:0] col = 16'h0000;
	logic [16:0] row = 17'h00000;
	logic smode = 1'b0;
	logic queued = 1'b0;
	logic we_q = 1'b1;
	logic re_q = 1'b1;
	logic f0 = 1'b0;
	logic f1 = 1'b0;
	int busy = 0;
	int abusy = 0;
	int ncmd = 0;

	assign rb = (busy == 0);
	assign sr = {1'b1, busy == 0, abusy == 0, 3'h0, f1, f0};
	// released pins show the inverse of the last byte so a stale copy cannot pass
	assign dout = (!ce_n && !re_n) ? (smode ? sr : cache[col[3:0]]) : ~last;

	always @(posedge clk_sys) begin
		we_q <= we_n;
		re_q <= re_n;
		if (busy > 0)
			busy <= busy - 1;
		if (abusy > 0)
			abusy <= abusy - 1;
		if (!re_n)
			last <= dout;
		if (re_n && !re_q && !smode)
			col <= col + 16'h0001;
		if (we_n && !we_q && !ce_n) begin
			if (cle) begin
				if (busy == 0 || din inside {8'h70, 8'h78, 8'hff}) begin
					ncmd <= ncmd + 1;
					ac <= 3'h0;
					smode <= din inside {8'h70, 8'h78};
					case (din)
					8'h80: if (!queued) for (int i = 0; i < 16; i++) cache[i] <= 8'hff;
					8'h11: begin
						busy <= 6;
						abusy <= 6;
						queued <= 1'b1;
					end
					8'h10, 8'h15: begin
						busy <= (din == 8'h10) ? abusy + 8 : abusy + 3;
						abusy <= abusy + ((din == 8'h10) ? 8 : 40);
						for (int i = 0; i < 16; i++) prog[i] <= cache[i];
						f1 <= f0;
						f0 <= fail_inj;
						queued <= 1'b0;
					end
					8'h35: begin
						busy <= 10;
						abusy <= 10;
						for (int i = 0; i < 16; i++) cache[i] <= prog[i];
					end
					default: ;
					endcase
				end
			end else if (ale) begin
				ac <= ac + 3'h1;
				case (ac)
				3'h0: col[7:0] <= din;
				3'h1: col[15:8] <= din;
				3'h2: row[7:0] <= din;
				3'h3: row[15:8] <= din;
				default: row[16] <= din[0];
				endcase
			end else begin
				cache[col[3:0]] <= din;
				col <= col + 16'h0001;
			end
		end
	end
endmodule // nmp_flash_model

// *** test/tb.sv ***
module tb import nmp_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] x; logic e;} nmp_row_t;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic clk_en = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic fail_inj = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, r;
	logic pready, pslverr, ce_n, cle, ale, we_n, re_n, io_oe_n, rb, e;
	logic [7:0] io_out, dev_out, io;
	int n_errors = 0;
	int n_checks = 0;
	int cyc = 0;
	nmp_row_t rows [6] = '{'{0, OFS_CFG, 0, 32'h2, 0}, '{0, OFS_STAT, 0, 32'h200, 0},
		'{1, OFS_COL, 32'h1234, 0, 0}, '{0, OFS_COL, 0, 32'h1234, 0},
		'{1, OFS_ROW, 32'h1_0280, 0, 0}, '{0, 8'h18, 0, 0, 1}};

	assign io = io_oe_n ? dev_out : io_out;

	nmp_ctrl u_nmp_ctrl (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .nand_ce_n(ce_n), .nand_cle(cle), .nand_ale(ale),
		.nand_we_n(we_n), .read_strobe_n(re_n), .nand_io_out(io_out), .nand_io_oe_n(io_oe_n),
		.nand_io_in(io), .ready_busy_n_pin(rb));
	nmp_flash_model u_nmp_flash_model (.clk_sys(clk_sys), .ce_n(ce_n), .cle(cle), .ale(ale),
		.we_n(we_n), .re_n(re_n), .din(io), .fail_inj(fail_inj), .dout(dev_out), .rb(rb));

	initial begin
		forever #12.5 clk_sys = ~clk_sys;
	end

	// a hung handshake must still end in the report
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			n_errors++;
			summarize();
		end
	end

	task automatic chk(input string name, input logic [31:0] x, input logic [31:0] g);
		n_checks++;
		if (g !== x) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, x, g);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic ee);
		apb(1'b1, a, d);
		chk("pslverr", {31'h0, ee}, {31'h0, e});
	endtask

	task automatic rd(input string n, input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(n, x, r & m);
	endtask

	task automatic cb(input int i, input logic [7:0] x);
		chk("stored byte", {24'h0, x}, {24'h0, u_nmp_flash_model.prog[i]});
	endtask

	task automatic idle();
		do begin
			apb(1'b0, OFS_STAT, 32'h0);
		end while (r[8] !== 1'b0);
	endtask

	function automatic logic [31:0] sq(input logic [7:0] c, input logic [2:0] n, input logic [2:0] f);
		return {18'h0, f, n, c};
	endfunction

	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial begin
		repeat (8) @(posedge clk_sys);
		sys_rst <= 1'b0;
		@(posedge clk_sys);
		foreach (rows[i]) begin
			apb(rows[i].w, rows[i].a, rows[i].d);
			chk("pslverr", {31'h0, rows[i].e}, {31'h0, e});
			if (!rows[i].w)
				chk("prdata", rows[i].x, r);
		end
		$display("test registers done");
		wr(OFS_COL, 32'h2, 0);
		wr(OFS_ROW, 32'h280, 0);
		wr(OFS_SEQ, sq(CMD_PROG_SETUP, 3'h5, 3'h0), 0);
		wr(OFS_DATA, 32'ha5, 0);
		wr(OFS_DATA, 32'h5a, 0);
		wr(OFS_COL, 32'h8, 0);
		wr(OFS_SEQ, sq(CMD_COL_CHANGE, 3'h2, 3'h0), 0);
		wr(OFS_DATA, 32'h3c, 0);
		wr(OFS_SEQ, sq(CMD_PROG, 3'h0, 3'h7), 0);
		idle();
		cb(2, 8'ha5);
		cb(3, 8'h5a);
		cb(8, 8'h3c);
		chk("row", 32'h280, {15'h0, u_nmp_flash_model.row});
		rd("status", OFS_STAT, 32'h4ff, 32'he0);
		$display("test page program done");
		fail_inj <= 1'b1;
		wr(OFS_SEQ, sq(CMD_PROG_SETUP, 3'h5, 3'h0), 0);
		wr(OFS_SEQ, sq(CMD_CACHE, 3'h0, 3'h1), 0);
		// the model latches the result only when its strobe arrives
		idle();
		fail_inj <= 1'b0;
		wr(OFS_SEQ, sq(CMD_PROG_SETUP, 3'h5, 3'h0), 0);
		wr(OFS_SEQ, sq(CMD_PROG, 3'h0, 3'h7), 0);
		idle();
		rd("status", OFS_STAT, 32'hcff, 32'h8e2);
		wr(OFS_STAT, 32'h3c00, 0);
		rd("flags", OFS_STAT, 32'h3c00, 32'h0);
		$display("test cache program done");
		wr(OFS_SEQ, sq(CMD_CACHE, 3'h0, 3'h4), 1);
		wr(OFS_ROW, 32'h100, 0);
		wr(OFS_SEQ, sq(CMD_PROG_SETUP, 3'h5, 3'h0), 0);
		wr(OFS_SEQ, sq(CMD_CACHE, 3'h0, 3'h0), 1);
		rd("refused", OFS_STAT, 32'h2000, 32'h2000);
		wr(OFS_STAT, 32'h2000, 0);
		$display("test boot guard done");
		wr(OFS_COL, 32'h0, 0);
		wr(OFS_ROW, 32'h280, 0);
		wr(OFS_SEQ, sq(CMD_PROG_SETUP, 3'h5, 3'h0), 0);
		wr(OFS_DATA, 32'h11, 0);
		wr(OFS_SEQ, sq(CMD_QUEUE, 3'h0, 3'h0), 0);
		wr(OFS_SEQ, sq(CMD_PROG, 3'h0, 3'h1), 1);
		rd("queued", OFS_STAT, 32'h4000, 32'h4000);
		wr(OFS_ROW, 32'h2c0, 0);
		wr(OFS_SEQ, sq(CMD_PLANE_SETUP, 3'h5, 3'h0), 0);
		wr(OFS_DATA, 32'h22, 0);
		wr(OFS_SEQ, sq(CMD_ERASE, 3'h0, 3'h0), 1);
		wr(OFS_SEQ, sq(CMD_PROG, 3'h0, 3'h7), 0);
		idle();
		cb(0, 8'h22);
		cb(1, 8'hff);
		chk("row", 32'h2c0, {15'h0, u_nmp_flash_model.row});
		$display("test two plane done");
		wr(OFS_ROW, 32'h280, 0);
		wr(OFS_SEQ, sq(CMD_READ, 3'h5, 3'h0), 0);
		wr(OFS_SEQ, sq(CMD_CB_READ, 3'h0, 3'h1), 0);
		rd("copy data", OFS_DATA, 32'hff, 32'h22);
		rd("copy data", OFS_DATA, 32'hff, 32'hff);
		wr(OFS_ROW, 32'h2c0, 0);
		wr(OFS_SEQ, sq(CMD_COL_CHANGE, 3'h5, 3'h0), 1);
		wr(OFS_STAT, 32'h2000, 0);
		wr(OFS_CFG, 32'h3, 0);
		wr(OFS_COL, 32'h1, 0);
		wr(OFS_ROW, 32'h300, 0);
		fail_inj <= 1'b1;
		wr(OFS_SEQ, sq(CMD_COL_CHANGE, 3'h5, 3'h0), 0);
		wr(OFS_DATA, 32'h77, 0);
		wr(OFS_SEQ, sq(CMD_PROG, 3'h0, 3'h7), 0);
		idle();
		fail_inj <= 1'b0;
		cb(0, 8'h22);
		cb(1, 8'h77);
		rd("status", OFS_STAT, 32'h4ff, 32'h4e1);
		$display("test copy back done");
		clk_en <= 1'b0;
		fork
			rd("frozen cfg", OFS_CFG, 32'h3, 32'h3);
			begin
				repeat (6) @(posedge clk_sys);
				chk("frozen pready", 32'h0, {31'h0, pready});
				clk_en <= 1'b1;
			end
		join
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		chk("reset ce_n", 32'h1, {31'h0, ce_n});
		sys_rst <= 1'b0;
		@(posedge clk_sys);
		rd("reset cfg", OFS_CFG, 32'h3, 32'h2);
		rd("reset stat", OFS_STAT, 32'h7dff, 32'h0);
		$display("test freeze and reset done");
		summarize();
	end
endmodule // tb
